// File: dv/sfg_host_model.sv
// host-side model: stalls the byte stream and parses each frame
module sfg_host_model (
    input  wire logic       clk,
    input  wire logic       sys_rst,
    input  wire logic [7:0] frameData,
    input  wire logic       frameValid,
    input  wire logic       frameLast,
    input  wire logic       stallOn,
    output logic            frameReady,
    output int              frameCount,
    output int              badCount
);
    timeunit 1ns;
    timeprecision 100ps;

    logic [7:0] rxBuf[$];
    int         seed   = 14;
    int         frames = 0;
    int         bad    = 0;

    assign frameCount = frames;
    assign badCount   = bad;

    // ------------------------------------------------------------
    // frame parse
    // ------------------------------------------------------------
    // filler bytes of the compat frame are checked only through the checksum
    task automatic check_frame();
        logic [7:0] s;
        int         n;
        s = 8'h00;
        n = rxBuf.size();
        for (int i = 3; i < n - 1; i++) begin
            s += rxBuf[i];
        end
        if (n < 5 || rxBuf[0] !== 8'h7e
            || {rxBuf[1], rxBuf[2]} !== 16'(n - 4)
            || rxBuf[n-1] !== 8'hff - s) begin
            bad++;
        end
        frames++;
        rxBuf.delete();
    endtask : check_frame

    always @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            frameReady <= 1'b0;
            rxBuf.delete();
        end else begin
            frameReady <= stallOn ? (($random(seed) & 3) != 0) : 1'b1;
            if (frameValid === 1'b1 && frameReady === 1'b1) begin
                rxBuf.push_back(frameData);
                if (frameLast === 1'b1) begin
                    check_frame();
                end
            end
        end
    end
endmodule : sfg_host_model

// File: dv/status_frame_generator_test.sv
// self-checking bench for the status frame generator
module status_frame_generator_test;
    timeunit 1ns;
    timeprecision 100ps;
    import sfg_pkg::*;

    logic           clk;
    logic           sys_rst;
    logic           resultValid;
    logic           resultReady;
    logic [7:0]     requestTag;
    logic [7:0]     requestType;
    sfg_result_type resultKind;
    logic           condValid;
    logic           condReady;
    sfg_cond_type   condKind;
    logic [7:0]     frameData;
    logic           frameValid;
    logic           frameReady;
    logic           frameLast;
    logic           stallOn;
    int             frameCount;
    int             badCount;
    int             error_cnt  = 0;
    int             num_checks = 0;
    int             seed       = 14;
    int             takes      = 0;
    int             condSeq;
    int             resultSeq;
    logic [8:0]     expQ[$];
    logic [7:0]     body[$];
    logic [7:0]     reqTypes[3] = '{8'h01, 8'h10, 8'h11};

    status_frame_generator i_dut (
        .clk(clk), .sys_rst(sys_rst), .resultValid(resultValid),
        .resultReady(resultReady), .requestTag(requestTag),
        .requestType(requestType), .resultKind(resultKind),
        .condValid(condValid), .condReady(condReady), .condKind(condKind),
        .frameData(frameData), .frameValid(frameValid),
        .frameReady(frameReady), .frameLast(frameLast)
    );

    sfg_host_model i_host (
        .clk(clk), .sys_rst(sys_rst), .frameData(frameData),
        .frameValid(frameValid), .frameLast(frameLast), .stallOn(stallOn),
        .frameReady(frameReady), .frameCount(frameCount),
        .badCount(badCount)
    );

    // ------------------------------------------------------------
    // expectations
    // ------------------------------------------------------------
    function automatic logic [7:0] result_code(input sfg_result_type k);
        case (k)
            SFG_RES_OK:        return 8'h00;
            SFG_RES_PURGED:    return 8'h03;
            SFG_RES_PHY:       return 8'h04;
            SFG_RES_ACK_TMO:   return 8'h21;
            SFG_RES_RESOURCE:  return 8'h32;
            SFG_RES_TOO_LONG:  return 8'h74;
            SFG_RES_SOCK_FAIL: return 8'h76;
            SFG_RES_NO_TCP:    return 8'h77;
            SFG_RES_UDP_PORT:  return 8'h78;
            default:           return 8'hee;
        endcase
    endfunction : result_code

    function automatic logic [7:0] cond_code(input sfg_cond_type k);
        case (k)
            SFG_EV_RESET:     return 8'h00;
            SFG_EV_WATCHDOG:  return 8'h01;
            SFG_EV_JOINED:    return 8'h02;
            SFG_EV_UNJOINED:  return 8'h03;
            SFG_EV_MGMT_UP:   return 8'h0e;
            SFG_EV_MGMT_DOWN: return 8'h0f;
            default:          return 8'hee;
        endcase
    endfunction : cond_code

    task automatic push_frame();
        logic [7:0] s;
        s = 8'h00;
        foreach (body[i]) s += body[i];
        expQ.push_back({1'b0, 8'h7e});
        expQ.push_back(9'h000);
        expQ.push_back({1'b0, 8'(body.size())});
        foreach (body[i]) expQ.push_back({1'b0, body[i]});
        expQ.push_back({1'b1, 8'hff - s});
    endtask : push_frame

    // ------------------------------------------------------------
    // checks and closing
    // ------------------------------------------------------------
    task automatic conclude();
        $display("checks %0d errors %0d", num_checks, error_cnt);
        if (error_cnt == 0 && num_checks > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask : conclude

    task automatic check(input string what, input logic [8:0] exp, got);
        num_checks++;
        if (got !== exp) begin
            error_cnt++;
            $display("Error %s expected %h seen %h", what, exp, got);
        end
    endtask : check

    task automatic timeout(input string what);
        error_cnt++;
        $display("Error %s expected done seen timeout", what);
        conclude();
    endtask : timeout

    always @(posedge clk) begin
        if (sys_rst === 1'b0 && frameValid === 1'b1
            && frameReady === 1'b1) begin
            if (expQ.size() == 0) begin
                check("unexpected byte", 9'h1ff, {1'b0, frameData});
            end else begin
                check("frame byte", expQ[0], {frameLast, frameData});
                void'(expQ.pop_front());
            end
        end
    end

    // ------------------------------------------------------------
    // drivers
    // ------------------------------------------------------------
    task automatic send_cond(input sfg_cond_type k);
        int n;
        @(posedge clk);
        condValid <= 1'b1;
        condKind  <= k;
        n = 0;
        do begin
            @(posedge clk);
            n++;
        end while (condReady !== 1'b1 && n < 300);
        condValid <= 1'b0;
        if (n >= 300) timeout("condReady");
        takes++;
        condSeq = takes;
        body = '{8'h8a, cond_code(k)};
        push_frame();
    endtask : send_cond

    task automatic send_result(input logic [7:0] tag, typ,
                               input sfg_result_type k);
        int         n;
        logic [7:0] c;
        @(posedge clk);
        resultValid <= 1'b1;
        requestTag  <= tag;
        requestType <= typ;
        resultKind  <= k;
        n = 0;
        do begin
            @(posedge clk);
            n++;
        end while (resultReady !== 1'b1 && n < 300);
        resultValid <= 1'b0;
        if (n >= 300) timeout("resultReady");
        takes++;
        resultSeq = takes;
        c = result_code(k);
        if (tag != 8'h00) begin
            if ((typ == 8'h10 || typ == 8'h11) && c != 8'h77 && c != 8'h78)
                body = '{8'h8b, tag, 8'hff, 8'hfe, 8'h00, c, 8'h00};
            else
                body = '{8'h89, tag, c};
            push_frame();
        end
    endtask : send_result

    task automatic drain();
        int n;
        n = 0;
        while (expQ.size() != 0 && n < 3000) begin
            @(posedge clk);
            n++;
        end
        if (expQ.size() != 0) timeout("drain");
        repeat (4) @(posedge clk);
    endtask : drain

    // ------------------------------------------------------------
    // stimulus
    // ------------------------------------------------------------
    initial begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end

    initial begin
        int         n;
        logic [31:0] r;
        sys_rst = 1'b1;
        resultValid = 1'b0;
        condValid = 1'b0;
        requestTag = 8'h00;
        requestType = 8'h00;
        resultKind = SFG_RES_OK;
        condKind = SFG_EV_RESET;
        stallOn = 1'b0;
        body = '{8'h8a, 8'h00};
        push_frame();
        repeat (12) @(posedge clk);
        sys_rst <= 1'b0;
        drain();
        for (int c = 0; c < 6; c++) send_cond(sfg_cond_type'(3'(c)));
        drain();
        foreach (reqTypes[t])
            for (int k = 0; k < 9; k++)
                send_result(8'(k + 1), reqTypes[t],
                            sfg_result_type'(4'(k)));
        drain();
        n = frameCount;
        send_result(8'h00, 8'h01, SFG_RES_OK);
        send_result(8'h00, 8'h10, SFG_RES_PHY);
        drain();
        check("frames for tag zero", 9'(n), 9'(frameCount));
        fork
            send_cond(SFG_EV_MGMT_UP);
            send_result(8'h5a, 8'h01, SFG_RES_TOO_LONG);
        join
        check("condition first", 9'h001, 9'(condSeq < resultSeq));
        // random traffic with a stalling host
        stallOn <= 1'b1;
        repeat (60) begin
            r = $random(seed);
            if (r[3:0] == 4'h0)
                send_cond(sfg_cond_type'(3'(r[11:4] % 6)));
            else
                send_result(r[5:4] == 2'b00 ? 8'h00 : r[15:8],
                            r[6] ? {7'h08, r[7]} : r[23:16],
                            sfg_result_type'(4'(r[31:24] % 9)));
        end
        drain();
        // reset in mid-frame brings back the power-up frame
        send_result(8'h33, 8'h11, SFG_RES_OK);
        n = 0;
        while (frameValid !== 1'b1 && n < 50) begin
            @(posedge clk);
            n++;
        end
        if (n >= 50) timeout("frameValid");
        repeat (2) @(posedge clk);
        sys_rst <= 1'b1;
        @(posedge clk);
        expQ.delete();
        body = '{8'h8a, 8'h00};
        push_frame();
        repeat (3) @(posedge clk);
        sys_rst <= 1'b0;
        send_result(8'hff, 8'h01, SFG_RES_UDP_PORT);
        drain();
        check("host bad frames", 9'h000, 9'(badCount));
        conclude();
    end
endmodule : status_frame_generator_test

// File: rtl/sfg_defines.svh
// constants for the status frame generator
`ifndef SFG_DEFINES_SVH
`define SFG_DEFINES_SVH
`define SFG_DELIM          8'h7e
`define SFG_TYPE_RESULT    8'h89
`define SFG_TYPE_COND      8'h8a
`define SFG_TYPE_COMPAT    8'h8b
`define SFG_REQ_COMPAT_A   8'h10
`define SFG_REQ_COMPAT_B   8'h11
`define SFG_LEN_RESULT     8'h03
`define SFG_LEN_COND       8'h02
`define SFG_LEN_COMPAT     8'h07
`define SFG_FILL5          8'hff
`define SFG_FILL6          8'hfe
`define SFG_FILL7          8'h00
`define SFG_FILL9          8'h00
`define SFG_CS_BASE        8'hff
`define SFG_ST_OK          8'h00
`define SFG_ST_PURGED      8'h03
`define SFG_ST_PHY         8'h04
`define SFG_ST_ACK_TMO     8'h21
`define SFG_ST_RESOURCE    8'h32
`define SFG_ST_TOO_LONG    8'h74
`define SFG_ST_SOCK_FAIL   8'h76
`define SFG_ST_NO_TCP      8'h77
`define SFG_ST_UDP_PORT    8'h78
`define SFG_CND_RESET      8'h00
`define SFG_CND_WATCHDOG   8'h01
`define SFG_CND_JOINED     8'h02
`define SFG_CND_UNJOINED   8'h03
`define SFG_CND_MGMT_UP    8'h0e
`define SFG_CND_MGMT_DOWN  8'h0f
`endif

// File: rtl/sfg_fifo.sv
// small valid/ready fifo for frame bytes
module sfg_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 4
) (
    input  wire logic             clk,
    input  wire logic             sys_rst,
    input  wire logic [WIDTH-1:0] inData,
    input  wire logic             inValid,
    output logic                  inReady,
    output logic [WIDTH-1:0]      outData,
    output logic                  outValid,
    input  wire logic             outReady
);
    localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
    // pointer arithmetic needs a power-of-two depth
    if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0 ||
        WIDTH < 1) begin : g_badParam
        $error("sfg_fifo: depth must be a power of two >= 2");
    end
    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW:0]      wrPtr_reg;
    logic [AW:0]      wrPtr_next;
    logic [AW:0]      rdPtr_reg;
    logic [AW:0]      rdPtr_next;
    logic             doWr;
    logic             doRd;
    always_comb begin
        inReady    = (wrPtr_reg - rdPtr_reg) != (AW + 1)'(DEPTH);
        outValid   = wrPtr_reg != rdPtr_reg;
        outData    = mem[rdPtr_reg[AW-1:0]];
        doWr       = inValid && inReady;
        doRd       = outValid && outReady;
        wrPtr_next = wrPtr_reg + (AW + 1)'(doWr);
        rdPtr_next = rdPtr_reg + (AW + 1)'(doRd);
    end
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            wrPtr_reg <= '0;
            rdPtr_reg <= '0;
        end else begin
            wrPtr_reg <= wrPtr_next;
            rdPtr_reg <= rdPtr_next;
        end
    end
    always_ff @(posedge clk) begin
        if (doWr) begin
            mem[wrPtr_reg[AW-1:0]] <= inData;
        end
    end
endmodule : sfg_fifo

// File: rtl/sfg_pkg.sv
// types for the status frame generator
package sfg_pkg;
    typedef enum logic [3:0] {
        SFG_IDLE = 4'b0001,
        SFG_HEAD = 4'b0010,
        SFG_BODY = 4'b0100,
        SFG_SUM  = 4'b1000
    } sfg_state_type;
    // outcome of a transmit attempt, mapped to a code by the framer
    typedef enum logic [3:0] {
        SFG_RES_OK, SFG_RES_PURGED, SFG_RES_PHY, SFG_RES_ACK_TMO,
        SFG_RES_RESOURCE, SFG_RES_TOO_LONG, SFG_RES_SOCK_FAIL,
        SFG_RES_NO_TCP, SFG_RES_UDP_PORT
    } sfg_result_type;
    typedef enum logic [2:0] {
        SFG_EV_RESET, SFG_EV_WATCHDOG, SFG_EV_JOINED, SFG_EV_UNJOINED,
        SFG_EV_MGMT_UP, SFG_EV_MGMT_DOWN
    } sfg_cond_type;
endpackage : sfg_pkg

// File: rtl/status_frame_generator.sv
// status frame generator: result, condition and compatibility frames
`include "sfg_defines.svh"
module status_frame_generator (
    input  wire logic                    clk,
    input  wire logic                    sys_rst,
    input  wire logic                    resultValid,
    output logic                         resultReady,
    input  wire logic [7:0]              requestTag,
    input  wire logic [7:0]              requestType,
    input  wire sfg_pkg::sfg_result_type resultKind,
    input  wire logic                    condValid,
    output logic                         condReady,
    input  wire sfg_pkg::sfg_cond_type   condKind,
    output logic [7:0]                   frameData,
    output logic                         frameValid,
    input  wire logic                    frameReady,
    output logic                         frameLast
);
    import sfg_pkg::*;

    // ----------------------------------------------------------------
    // code mapping
    // ----------------------------------------------------------------
    function automatic logic [7:0] resultCode(sfg_result_type k);
        unique case (k)
            SFG_RES_OK:        return `SFG_ST_OK;
            SFG_RES_PURGED:    return `SFG_ST_PURGED;
            SFG_RES_PHY:       return `SFG_ST_PHY;
            SFG_RES_ACK_TMO:   return `SFG_ST_ACK_TMO;
            SFG_RES_RESOURCE:  return `SFG_ST_RESOURCE;
            SFG_RES_TOO_LONG:  return `SFG_ST_TOO_LONG;
            SFG_RES_SOCK_FAIL: return `SFG_ST_SOCK_FAIL;
            SFG_RES_NO_TCP:    return `SFG_ST_NO_TCP;
            SFG_RES_UDP_PORT:  return `SFG_ST_UDP_PORT;
            default:           return `SFG_ST_PHY;
        endcase
    endfunction : resultCode

    function automatic logic [7:0] condCode(sfg_cond_type k);
        unique case (k)
            SFG_EV_RESET:     return `SFG_CND_RESET;
            SFG_EV_WATCHDOG:  return `SFG_CND_WATCHDOG;
            SFG_EV_JOINED:    return `SFG_CND_JOINED;
            SFG_EV_UNJOINED:  return `SFG_CND_UNJOINED;
            SFG_EV_MGMT_UP:   return `SFG_CND_MGMT_UP;
            SFG_EV_MGMT_DOWN: return `SFG_CND_MGMT_DOWN;
            default:          return `SFG_CND_RESET;
        endcase
    endfunction : condCode

    // ----------------------------------------------------------------
    // framer state
    // ----------------------------------------------------------------
    sfg_state_type state_reg;
    sfg_state_type state_next;
    logic [7:0]    body_reg [7];
    logic [7:0]    body_next [7];
    logic [2:0]    bodyLen_reg;
    logic [2:0]    bodyLen_next;
    logic [2:0]    idx_reg;
    logic [2:0]    idx_next;
    logic [7:0]    sum_reg;
    logic [7:0]    sum_next;
    logic          bootPend_reg;
    logic          bootPend_next;
    logic          resReady_reg;
    logic          resReady_next;
    logic          cndReady_reg;
    logic          cndReady_next;
    logic [7:0]    pushData;
    logic          pushValid;
    logic          pushReady;
    logic          pushLast;
    logic          isCompat;
    logic [7:0]    rCode;

    always_comb begin
        state_next    = state_reg;
        body_next     = body_reg;
        bodyLen_next  = bodyLen_reg;
        idx_next      = idx_reg;
        sum_next      = sum_reg;
        bootPend_next = bootPend_reg;
        resReady_next = 1'b0;
        cndReady_next = 1'b0;
        pushData      = 8'h00;
        pushValid     = 1'b0;
        pushLast      = 1'b0;
        isCompat      = (requestType == `SFG_REQ_COMPAT_A) ||
                        (requestType == `SFG_REQ_COMPAT_B);
        rCode         = resultCode(resultKind);
        unique case (state_reg)
            SFG_IDLE: begin
                idx_next = 3'd0;
                sum_next = 8'h00;
                if (bootPend_reg) begin
                    // power-up condition report first
                    bootPend_next = 1'b0;
                    body_next[0]  = `SFG_TYPE_COND;
                    body_next[1]  = `SFG_CND_RESET;
                    bodyLen_next  = 3'(`SFG_LEN_COND);
                    state_next    = SFG_HEAD;
                end else if (condValid && !cndReady_reg) begin
                    cndReady_next = 1'b1;
                    body_next[0]  = `SFG_TYPE_COND;
                    body_next[1]  = condCode(condKind);
                    bodyLen_next  = 3'(`SFG_LEN_COND);
                    state_next    = SFG_HEAD;
                end else if (resultValid && !resReady_reg) begin
                    resReady_next = 1'b1;
                    if (requestTag != 8'h00) begin
                        state_next = SFG_HEAD;
                        if (isCompat && rCode != `SFG_ST_NO_TCP &&
                            rCode != `SFG_ST_UDP_PORT) begin
                            body_next[0] = `SFG_TYPE_COMPAT;
                            body_next[1] = requestTag;
                            body_next[2] = `SFG_FILL5;
                            body_next[3] = `SFG_FILL6;
                            body_next[4] = `SFG_FILL7;
                            body_next[5] = rCode;
                            body_next[6] = `SFG_FILL9;
                            bodyLen_next = 3'(`SFG_LEN_COMPAT);
                        end else begin
                            body_next[0] = `SFG_TYPE_RESULT;
                            body_next[1] = requestTag;
                            body_next[2] = rCode;
                            bodyLen_next = 3'(`SFG_LEN_RESULT);
                        end
                    end
                end
            end
            SFG_HEAD: begin
                // delimiter, then length msb, then length lsb
                unique case (idx_reg)
                    3'd0:    pushData = `SFG_DELIM;
                    3'd1:    pushData = 8'h00;
                    default: pushData = {5'h00, bodyLen_reg};
                endcase
                pushValid = 1'b1;
                if (pushReady) begin
                    idx_next = idx_reg + 3'd1;
                    if (idx_reg == 3'd2) begin
                        idx_next   = 3'd0;
                        state_next = SFG_BODY;
                    end
                end
            end
            SFG_BODY: begin
                pushData  = body_reg[idx_reg];
                pushValid = 1'b1;
                if (pushReady) begin
                    sum_next = sum_reg + body_reg[idx_reg];
                    idx_next = idx_reg + 3'd1;
                    if (idx_reg == bodyLen_reg - 3'd1) begin
                        state_next = SFG_SUM;
                    end
                end
            end
            SFG_SUM: begin
                pushData  = `SFG_CS_BASE - sum_reg;
                pushValid = 1'b1;
                pushLast  = 1'b1;
                if (pushReady) begin
                    state_next = SFG_IDLE;
                end
            end
        endcase
    end

    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            state_reg    <= SFG_IDLE;
            bodyLen_reg  <= 3'd0;
            idx_reg      <= 3'd0;
            sum_reg      <= 8'h00;
            bootPend_reg <= 1'b1;
            resReady_reg <= 1'b0;
            cndReady_reg <= 1'b0;
            for (int i = 0; i < 7; i++) begin
                body_reg[i] <= 8'h00;
            end
        end else begin
            state_reg    <= state_next;
            body_reg     <= body_next;
            bodyLen_reg  <= bodyLen_next;
            idx_reg      <= idx_next;
            sum_reg      <= sum_next;
            bootPend_reg <= bootPend_next;
            resReady_reg <= resReady_next;
            cndReady_reg <= cndReady_next;
        end
    end

    assign resultReady = resReady_reg;
    assign condReady   = cndReady_reg;

    // ----------------------------------------------------------------
    // output buffer: byte plus last flag
    // ----------------------------------------------------------------
    logic [8:0] fifoOut;
    logic       fifoValid;
    logic       takeOut;
    logic [7:0] outData_reg;
    logic       outValid_reg;
    logic       outLast_reg;
    logic [7:0] outData_next;
    logic       outValid_next;
    logic       outLast_next;

    sfg_fifo #(.WIDTH(9), .DEPTH(4)) u_fifo (
        .clk      (clk),
        .sys_rst  (sys_rst),
        .inData   ({pushLast, pushData}),
        .inValid  (pushValid),
        .inReady  (pushReady),
        .outData  (fifoOut),
        .outValid (fifoValid),
        .outReady (takeOut)
    );

    always_comb begin
        takeOut       = !outValid_reg || frameReady;
        outData_next  = outData_reg;
        outValid_next = outValid_reg;
        outLast_next  = outLast_reg;
        if (takeOut) begin
            outData_next  = fifoOut[7:0];
            outValid_next = fifoValid;
            outLast_next  = fifoOut[8] && fifoValid;
        end
    end

    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            outData_reg  <= 8'h00;
            outValid_reg <= 1'b0;
            outLast_reg  <= 1'b0;
        end else begin
            outData_reg  <= outData_next;
            outValid_reg <= outValid_next;
            outLast_reg  <= outLast_next;
        end
    end

    assign frameData  = outData_reg;
    assign frameValid = outValid_reg;
    assign frameLast  = outLast_reg;

    // ----------------------------------------------------------------
    // checks
    // ----------------------------------------------------------------
    sequence startSeq;
        state_reg == SFG_IDLE && resultValid && !resReady_reg &&
        !bootPend_reg && !(condValid && !cndReady_reg);
    endsequence

    sequence headStartSeq;
        state_reg == SFG_IDLE ##1 state_reg == SFG_HEAD;
    endsequence

    zero_tag_a: assert property (
        @(posedge clk) disable iff (sys_rst)
        startSeq and requestTag == 8'h00 |=> state_reg == SFG_IDLE)
        else $error("frame started for zero tag");
    result_type_a: assert property (
        @(posedge clk) disable iff (sys_rst)
        startSeq and requestTag != 8'h00 and !isCompat
        |=> body_reg[0] == 8'h89 && body_reg[1] == $past(requestTag))
        else $error("result frame type or tag wrong");
    compat_type_a: assert property (
        @(posedge clk) disable iff (sys_rst)
        startSeq and requestTag != 8'h00 and isCompat and
        rCode != 8'h77 and rCode != 8'h78
        |=> body_reg[0] == 8'h8b && bodyLen_reg == 3'd7)
        else $error("compat frame not chosen");
    code_map_a: assert property (
        @(posedge clk) disable iff (sys_rst)
        startSeq and requestTag != 8'h00 and !isCompat
        and resultKind == SFG_RES_NO_TCP |=> body_reg[2] == 8'h77)
        else $error("tcp code wrong");
    delim_first_a: assert property (
        @(posedge clk) disable iff (sys_rst)
        headStartSeq |-> pushData == 8'h7e)
        else $error("frame does not open with delimiter");
    boot_frame_a: assert property (
        @(posedge clk) disable iff (sys_rst)
        $fell(bootPend_reg) |-> body_reg[0] == 8'h8a &&
        body_reg[1] == 8'h00 && bodyLen_reg == 3'd2)
        else $error("power-up frame wrong");
    cond_frame_a: assert property (
        @(posedge clk) disable iff (sys_rst)
        $rose(cndReady_reg) |-> body_reg[0] == 8'h8a &&
        body_reg[1] == condCode($past(condKind)))
        else $error("condition frame wrong");
    checksum_byte_a: assert property (
        @(posedge clk) disable iff (sys_rst)
        state_reg == SFG_SUM |-> pushData == 8'(8'hff - sum_reg))
        else $error("checksum byte wrong");
endmodule : status_frame_generator
